// >>> bench/kcs_remote_src.sv
// Remote command source model: registers the bench's run request onto the remote lines.
// Assumes the controller's clock and reset.
`timescale 1ns/1ps
`default_nettype none

module kcs_remote_src (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Requests from the bench
  input wire logic runReq,
  input wire logic [15:0] freqReq,
  // Remote command lines
  output logic remoteRun,
  output logic remoteReverse,
  output logic [15:0] remoteFreq
);
  assign remoteReverse = 1'b0;

  // Run is withdrawn and reissued only on request, as after a stop key stop
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      remoteRun <= 1'b0;
      remoteFreq <= 16'h0000;
    end
    else
    begin
      remoteRun <= runReq;
      remoteFreq <= freqReq;
    end
  end
endmodule : kcs_remote_src

`default_nettype wire

// >>> bench/keypad_command_source_ctrl_test.sv
// Self-checking bench for the keypad command source controller.
// Assumes the package, the design and the remote source model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module keypad_command_source_ctrl_test;
  logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00, faultCode = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, localLamp, runCmd, reverseCmd, freqSaveStrobe, remoteRun, remoteReverse;
  logic runReq = 0, ova = 0, fanRunning = 0, faultEvent = 0;
  logic [15:0] remoteFreq, freqCmd, savedFreq;
  logic [5:0] capacityStrap = 6'h00;
  kcs_pkg::kcs_keys_t keys = '0;
  int errCount = 0, nTests = 0, seed = 36373, n, k;

  always #5 mclk = ~mclk;

  kcs_ctrl #(.SAVE_CYCLES(32'h0000_0014), .HOUR_CYCLES(40'h00_0000_0010)) dut (.mclk(mclk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .keys(keys),
    .localLamp(localLamp), .remoteRun(remoteRun), .remoteReverse(remoteReverse),
    .remoteFreq(remoteFreq), .capacityStrap(capacityStrap), .outputVoltageActive(ova),
    .fanRunning(fanRunning), .faultEvent(faultEvent), .faultCode(faultCode), .runCmd(runCmd),
    .reverseCmd(reverseCmd), .freqCmd(freqCmd), .freqSaveStrobe(freqSaveStrobe),
    .savedFreq(savedFreq));

  kcs_remote_src src (.mclk(mclk), .arst_n(arst_n), .runReq(runReq), .freqReq(16'h1234),
    .remoteRun(remoteRun), .remoteReverse(remoteReverse), .remoteFreq(remoteFreq));

  // ***************
  // Tasks
  // ***************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tallyAndFinish();
    $display("Checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tallyAndFinish

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rdchk

  task automatic wt(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : wt

  task automatic press(input logic [5:0] key);
    @(posedge mclk);
    keys <= kcs_pkg::kcs_keys_t'(key);
    @(posedge mclk);
    keys <= '0;
    wt(3);
  endtask : press

  task automatic doReset();
    arst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    wt(2);
  endtask : doReset

  task automatic run(input logic r);
    @(posedge mclk);
    runReq <= r;
    wt(3);
  endtask : run

  task automatic hours(input string what, input logic [7:0] a, input logic [31:0] lo);
    wt(70);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, 32'h0000_0001, 32'(rd >= lo && rd <= lo + 1));
  endtask : hours

  // ***************
  // Tests
  // ***************
  initial
  begin
    #100_000;
    errCount++;
    tallyAndFinish();
  end

  initial
  begin
    capacityStrap <= 6'($unsigned($random(seed)) % 15);
    n = $unsigned($random(seed)) % 6 + 1;
    doReset();
    rdchk("ctrl", kcs_pkg::REG_CTRL, 32'h0000_0005);
    rdchk("cap", kcs_pkg::REG_CAP, 32'(capacityStrap));
    apb(1'b1, kcs_pkg::REG_CAP, 32'h0000_000E);
    apb(1'b1, kcs_pkg::REG_CAP, 32'h0000_000F);
    rdchk("cap", kcs_pkg::REG_CAP, 32'h0000_000E);
    apb(1'b1, kcs_pkg::REG_CAP, 32'h0000_0020);
    rdchk("cap", kcs_pkg::REG_CAP, 32'h0000_0020);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk("slverr", 1, err);
    $display("test capacity done");
    apb(1'b1, kcs_pkg::REG_CTRL, 32'h0000_0004);
    press(6'h20);
    chk("lamp", 0, localLamp);
    apb(1'b1, kcs_pkg::REG_CTRL, 32'h0000_0005);
    press(6'h20);
    chk("lamp", 1, localLamp);
    press(6'h20);
    chk("lamp", 0, localLamp);
    run(1'b1);
    chk("run", 1, runCmd);
    press(6'h20);
    chk("lamp", 0, localLamp);
    run(1'b0);
    press(6'h20);
    chk("lamp", 1, localLamp);
    run(1'b1);
    press(6'h20);
    chk("run", 0, runCmd);
    run(1'b0);
    run(1'b1);
    chk("run", 1, runCmd);
    press(6'h10);
    chk("run", 0, runCmd);
    wt(6);
    chk("run", 0, runCmd);
    run(1'b0);
    run(1'b1);
    chk("run", 1, runCmd);
    run(1'b0);
    $display("test switching done");
    press(6'h20);
    apb(1'b1, kcs_pkg::REG_CTRL, 32'h0000_0007);
    run(1'b1);
    press(6'h20);
    chk("run", 1, runCmd);
    run(1'b0);
    press(6'h20);
    repeat (n) press(6'h04);
    chk("freq", 0, freqCmd);
    press(6'h01);
    chk("freq", n, freqCmd);
    apb(1'b1, kcs_pkg::REG_CTRL, 32'h0000_000F);
    press(6'h04);
    chk("freq", n + 1, freqCmd);
    k = 0;
    while (freqSaveStrobe !== 1'b1 && k < 40)
    begin
      wt(1);
      k++;
    end
    chk("savedelay", 17, k);
    chk("saved", n + 1, savedFreq);
    apb(1'b1, kcs_pkg::REG_CTRL, 32'h0000_001F);
    press(6'h08);
    chk("reverse", 1, reverseCmd);
    $display("test keypad done");
    doReset();
    apb(1'b1, kcs_pkg::REG_CTRL, 32'h0000_0155);
    press(6'h20);
    press(6'h08);
    chk("reverse", 0, reverseCmd);
    apb(1'b1, kcs_pkg::REG_OPTIME, 32'h0000_0014);
    rdchk("ophours", kcs_pkg::REG_OPTIME, 32'h0000_00C8);
    hours("ophours", kcs_pkg::REG_OPTIME, 32'h0000_00CC);
    apb(1'b1, kcs_pkg::REG_CTRL, 32'h0000_0175);
    apb(1'b1, kcs_pkg::REG_OPTIME, 32'h0000_0014);
    hours("ophours", kcs_pkg::REG_OPTIME, 32'h0000_00C8);
    ova <= 1'b1;
    hours("ophours", kcs_pkg::REG_OPTIME, 32'h0000_00CC);
    ova <= 1'b0;
    apb(1'b1, kcs_pkg::REG_OPTIME, 32'h0000_02BC);
    rdchk("ophours", kcs_pkg::REG_OPTIME, 32'h0000_1770);
    apb(1'b1, kcs_pkg::REG_FANTIME, 32'h0000_0003);
    rdchk("fanhours", kcs_pkg::REG_FANTIME, 32'h0000_001E);
    fanRunning <= 1'b1;
    hours("fanhours", kcs_pkg::REG_FANTIME, 32'h0000_0022);
    $display("test hours done");
    faultCode <= 8'($random(seed));
    faultEvent <= 1'b1;
    @(posedge mclk);
    faultEvent <= 1'b0;
    apb(1'b1, kcs_pkg::REG_INIT, 32'h0000_0001);
    rdchk("ctrl", kcs_pkg::REG_CTRL, 32'h0000_0005);
    rdchk("faults", kcs_pkg::REG_FAULTREC, 32'(faultCode));
    apb(1'b1, kcs_pkg::REG_FAULTCLR, 32'h0000_0000);
    press(6'h01);
    rdchk("faults", kcs_pkg::REG_FAULTREC, 32'(faultCode));
    apb(1'b1, kcs_pkg::REG_FAULTCLR, 32'h0000_0001);
    press(6'h01);
    rdchk("faults", kcs_pkg::REG_FAULTREC, 32'h0000_0000);
    $display("test faults done");
    tallyAndFinish();
  end
endmodule : keypad_command_source_ctrl_test

`default_nettype wire

// >>> logic/kcs_ctrl.sv
// Keypad command source controller: local/remote switching, stop override,
// keypad frequency entry, power-up direction, hour counters and fault history.
// Assumes keys arrive as one-cycle synchronous pulses and remote inputs are synchronous.
//
// Summary of operation
// - Switch enable 0 ignores the local/remote key entirely.
// - Switch enable 1 toggles source only while no run command is output.
// - Local/remote lamp lights exactly while local mode is selected.
// - Run-after-switch 1 starts at once on an already active remote run.
// - Run-after-switch 0 holds the drive stopped until a fresh remote run.
// - Stop override 1 lets the stop key stop a remotely commanded drive.
// - After a stop key stop, run must be removed and reapplied.
// - Capacity code preset from strap; accepts codes 0-14 and 32-46.
// - Enter-required 0 applies edited frequency only on the enter key.
// - Enter-required 1 applies up/down at once, saves 5 s later.
// - First keypad run after power-up uses the power-up direction setting.
// - Power-up direction applies only locally with a keypad run source.
// - Operation time preset loads the hour counter with value times ten, value capped at 600.
// - Operation counter counts always in mode 0, during output in mode 1.
// - Fan time preset loads the fan hour counter in tens of hours, capped at 600 tens.
// - Fault clear armed by 1 then enter zeroes all fault records.
// - Parameter initialise restores settings but keeps fault records.
`timescale 1ns/1ps
`default_nettype none

module kcs_ctrl #(
  parameter logic [31:0] SAVE_CYCLES = 32'(kcs_pkg::FREQ_SAVE_CYCLES),
  parameter logic [39:0] HOUR_CYCLES = 40'(kcs_pkg::HOUR_CYCLES)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Keypad
  input wire kcs_pkg::kcs_keys_t keys,
  output logic localLamp,
  // Remote command source
  input wire logic remoteRun,
  input wire logic remoteReverse,
  input wire logic [kcs_pkg::FREQ_W-1:0] remoteFreq,
  // Drive status
  input wire logic [kcs_pkg::CAP_W-1:0] capacityStrap,
  input wire logic outputVoltageActive,
  input wire logic fanRunning,
  input wire logic faultEvent,
  input wire logic [kcs_pkg::FAULT_W-1:0] faultCode,
  // Drive commands
  output logic runCmd,
  output logic reverseCmd,
  output logic [kcs_pkg::FREQ_W-1:0] freqCmd,
  output logic freqSaveStrobe,
  output logic [kcs_pkg::FREQ_W-1:0] savedFreq
);

  // ***********************************************
  // State
  // ***********************************************
  kcs_pkg::kcs_cfg_t cfg_q;
  logic [kcs_pkg::CAP_W-1:0] cap_q;
  logic capLoaded_q;
  logic local_q;
  logic localRun_q;
  logic remoteBlock_q;
  logic firstRunDone_q;
  logic localRev_q;
  logic [kcs_pkg::FREQ_W-1:0] editFreq_q;
  logic [kcs_pkg::FREQ_W-1:0] activeFreq_q;
  logic [31:0] saveCnt_q;
  logic savePending_q;
  logic clearArmed_q;
  logic [kcs_pkg::FAULT_W-1:0] faultRec_q [kcs_pkg::FAULT_DEPTH];
  logic [kcs_pkg::FAULT_DEPTH*kcs_pkg::FAULT_W-1:0] faultFlat;
  logic [kcs_pkg::HOURS_W-1:0] opHours;
  logic [kcs_pkg::HOURS_W-1:0] fanHours;
  logic hourTick;

  // ***********************************************
  // APB decode
  // ***********************************************
  wire apbWr = psel & penable & pwrite;
  wire apbSetup = psel & ~penable;
  wire hitCtrl = (paddr == kcs_pkg::REG_CTRL);
  wire hitCap = (paddr == kcs_pkg::REG_CAP);
  wire hitOp = (paddr == kcs_pkg::REG_OPTIME);
  wire hitFan = (paddr == kcs_pkg::REG_FANTIME);
  wire hitClr = (paddr == kcs_pkg::REG_FAULTCLR);
  wire hitRec = (paddr == kcs_pkg::REG_FAULTREC);
  wire hitInit = (paddr == kcs_pkg::REG_INIT);
  wire hitStat = (paddr == kcs_pkg::REG_STATUS);
  wire hitFreq = (paddr == kcs_pkg::REG_FREQ);
  wire hitSaved = (paddr == kcs_pkg::REG_SAVED);
  wire mapped = hitCtrl | hitCap | hitOp | hitFan | hitClr | hitRec | hitInit | hitStat
    | hitFreq | hitSaved;
  wire wrCtrl = apbWr & hitCtrl;
  wire wrCap = apbWr & hitCap;
  wire wrOp = apbWr & hitOp;
  wire wrFan = apbWr & hitFan;
  wire wrClr = apbWr & hitClr;
  wire wrInit = apbWr & hitInit & pwdata[kcs_pkg::INIT_BIT];

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ***********************************************
  // Settings and capacity code
  // ***********************************************
  wire [kcs_pkg::CAP_W-1:0] capWr = pwdata[kcs_pkg::CAP_W-1:0];
  wire capLegal = (capWr <= kcs_pkg::CAP_200V_MAX)
    | ((capWr >= kcs_pkg::CAP_400V_MIN) & (capWr <= kcs_pkg::CAP_400V_MAX));

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      cfg_q <= kcs_pkg::CTRL_RESET;
    else if (wrInit)
      cfg_q <= kcs_pkg::CTRL_RESET;
    else if (wrCtrl)
      cfg_q <= pwdata[kcs_pkg::CTRL_W-1:0];
  end

  // Strap caught on the first edge after reset release
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cap_q <= '0;
      capLoaded_q <= 1'b0;
    end
    else if (!capLoaded_q)
    begin
      cap_q <= capacityStrap;
      capLoaded_q <= 1'b1;
    end
    else if (wrCap && capLegal)
      cap_q <= capWr;
  end

  // ***********************************************
  // Command source and run control
  // ***********************************************
  wire runSel = local_q ? localRun_q : (remoteRun & ~remoteBlock_q);
  // A run about to be issued counts as running, so no toggle slips in
  wire toggleOk = keys.localRemote & cfg_q.sourceSwitchEnable & ~runCmd & ~runSel;
  wire stopKill = keys.stop & (local_q | cfg_q.stopKeyOverride);
  wire toRemoteHold = toggleOk & local_q & ~cfg_q.runAfterSwitchSelect;
  wire keypadSrc = (cfg_q.runSourceSelectPrimary == kcs_pkg::SRC_KEYPAD)
    | (cfg_q.runSourceSelectSecondary == kcs_pkg::SRC_KEYPAD);
  wire localRunKey = keys.run & local_q & ~keys.stop;
  wire powerupApplies = localRunKey & ~firstRunDone_q & keypadSrc;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      local_q <= 1'b0;
    else if (toggleOk)
      local_q <= ~local_q;
  end

  // A remote run stays blocked until it is seen removed or local mode is selected; the set wins
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      remoteBlock_q <= 1'b0;
    else if (toRemoteHold || (stopKill && !local_q))
      remoteBlock_q <= 1'b1;
    else if (!remoteRun || local_q)
      remoteBlock_q <= 1'b0;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      localRun_q <= 1'b0;
    else if (stopKill || toggleOk)
      localRun_q <= 1'b0;
    else if (localRunKey)
      localRun_q <= 1'b1;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      firstRunDone_q <= 1'b0;
      localRev_q <= 1'b0;
    end
    else if (localRunKey)
    begin
      firstRunDone_q <= 1'b1;
      if (powerupApplies)
        localRev_q <= cfg_q.powerupDirectionSelect;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      runCmd <= 1'b0;
      reverseCmd <= 1'b0;
    end
    else
    begin
      runCmd <= runSel & ~stopKill;
      reverseCmd <= local_q ? localRev_q : remoteReverse;
    end
  end

  assign localLamp = local_q;

  // ***********************************************
  // Frequency entry
  // ***********************************************
  wire stepUp = local_q & keys.up & (editFreq_q != kcs_pkg::FREQ_MAX);
  wire stepDn = local_q & keys.down & ~keys.up & (editFreq_q != '0);
  wire stepAny = stepUp | stepDn;
  wire [kcs_pkg::FREQ_W-1:0] editNext = stepUp ? editFreq_q + kcs_pkg::FREQ_STEP
    : stepDn ? editFreq_q - kcs_pkg::FREQ_STEP : editFreq_q;
  wire immediate = cfg_q.enterRequiredSelect;
  wire saveDone = savePending_q & (saveCnt_q == '0);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      editFreq_q <= '0;
    else
      editFreq_q <= editNext;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      activeFreq_q <= '0;
    else if (immediate)
      activeFreq_q <= editNext;
    else if (local_q && keys.enter)
      activeFreq_q <= editFreq_q;
  end

  // Each new step restarts the save delay
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      saveCnt_q <= '0;
      savePending_q <= 1'b0;
    end
    else if (immediate && stepAny)
    begin
      saveCnt_q <= SAVE_CYCLES - 32'h0000_0001;
      savePending_q <= 1'b1;
    end
    else if (saveDone)
      savePending_q <= 1'b0;
    else if (savePending_q)
      saveCnt_q <= saveCnt_q - 32'h0000_0001;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      freqSaveStrobe <= 1'b0;
      savedFreq <= '0;
      freqCmd <= '0;
    end
    else
    begin
      freqSaveStrobe <= saveDone;
      if (saveDone)
        savedFreq <= activeFreq_q;
      freqCmd <= local_q ? activeFreq_q : remoteFreq;
    end
  end

  // ***********************************************
  // Fault history
  // ***********************************************
  wire faultClear = keys.enter & clearArmed_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      clearArmed_q <= 1'b0;
    else if (wrClr)
      clearArmed_q <= pwdata[kcs_pkg::CLR_ARM_BIT];
    else if (faultClear)
      clearArmed_q <= 1'b0;
  end

  // Newest record in entry 0; an event in the clearing cycle is kept
  for (genvar i = 0; i < kcs_pkg::FAULT_DEPTH; i++)
  begin : g_fault
    wire [kcs_pkg::FAULT_W-1:0] shiftIn;
    if (i == 0)
    begin : g_head
      assign shiftIn = faultCode;
    end
    else
    begin : g_tail
      assign shiftIn = faultClear ? '0 : faultRec_q[i-1];
    end
    always_ff @(posedge mclk or negedge arst_n)
    begin
      if (!arst_n)
        faultRec_q[i] <= '0;
      else if (faultEvent)
        faultRec_q[i] <= shiftIn;
      else if (faultClear)
        faultRec_q[i] <= '0;
    end
    assign faultFlat[i*kcs_pkg::FAULT_W +: kcs_pkg::FAULT_W] = faultRec_q[i];
  end

  // ***********************************************
  // Hour counters
  // ***********************************************
  wire [kcs_pkg::HOURS_W-1:0] presetIn = pwdata[kcs_pkg::HOURS_W-1:0];
  wire [kcs_pkg::HOURS_W-1:0] presetClip =
    (presetIn > kcs_pkg::PRESET_MAX) ? kcs_pkg::PRESET_MAX : presetIn;
  wire [kcs_pkg::HOURS_W-1:0] presetHours = 16'(presetClip * kcs_pkg::HOURS_PER_UNIT);
  wire opEnable = cfg_q.operationTimeMode ? outputVoltageActive : 1'b1;

  kcs_tick_div #(.DIV(HOUR_CYCLES)) u_hourDiv (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(hourTick)
  );

  kcs_hour_counter u_opHours (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(hourTick),
    .enable(opEnable),
    .load(wrOp),
    .loadValue(presetHours),
    .hours(opHours)
  );

  kcs_hour_counter u_fanHours (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(hourTick),
    .enable(fanRunning),
    .load(wrFan),
    .loadValue(presetHours),
    .hours(fanHours)
  );

  // ***********************************************
  // Read data, captured in the setup phase
  // ***********************************************
  wire [31:0] statusWord = {26'h000_0000, remoteBlock_q, firstRunDone_q, savePending_q,
    reverseCmd, runCmd, local_q};
  wire [31:0] rdMux =
      hitCtrl ? {{(32-kcs_pkg::CTRL_W){1'b0}}, cfg_q}
    : hitCap ? {{(32-kcs_pkg::CAP_W){1'b0}}, cap_q}
    : hitOp ? {16'h0000, opHours}
    : hitFan ? {16'h0000, fanHours}
    : hitClr ? {31'h0000_0000, clearArmed_q}
    : hitRec ? faultFlat
    : hitStat ? statusWord
    : hitFreq ? {editFreq_q, activeFreq_q}
    : hitSaved ? {16'h0000, savedFreq}
    : 32'h0000_0000;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= '0;
    else if (apbSetup && !pwrite)
      prdata <= rdMux;
  end

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_switchOff;
    !cfg_q.sourceSwitchEnable |=> local_q == $past(local_q);
  endproperty
  a_switchOff: assert property (p_switchOff) else $error("source changed while disabled");

  property p_noToggleRunning;
    runCmd |=> local_q == $past(local_q);
  endproperty
  a_noToggleRunning: assert property (p_noToggleRunning) else $error("toggle while running");

  property p_lampToggles;
    keys.localRemote && cfg_q.sourceSwitchEnable && !runCmd && !runSel
      |=> localLamp != $past(localLamp);
  endproperty
  a_lampToggles: assert property (p_lampToggles) else $error("lamp did not follow switch");

  property p_runAfter;
    toggleOk && local_q && cfg_q.runAfterSwitchSelect && remoteRun && !keys.stop
      ##1 remoteRun && !keys.stop && !remoteBlock_q |=> runCmd;
  endproperty
  a_runAfter: assert property (p_runAfter) else $error("active remote run not taken");

  property p_holdAfter;
    toRemoteHold |-> ##2 !runCmd;
  endproperty
  a_holdAfter: assert property (p_holdAfter) else $error("ran without fresh command");

  property p_stopKey;
    keys.stop && cfg_q.stopKeyOverride |=> !runCmd ##1 (!runCmd || !local_q || localRun_q);
  endproperty
  a_stopKey: assert property (p_stopKey) else $error("stop key did not stop");

  property p_enterHold;
    !cfg_q.enterRequiredSelect && !keys.enter |=> $stable(activeFreq_q);
  endproperty
  a_enterHold: assert property (p_enterHold) else $error("frequency applied without enter");

  property p_immediate;
    cfg_q.enterRequiredSelect && stepUp |=> activeFreq_q == 16'($past(editFreq_q) + 16'h0001);
  endproperty
  a_immediate: assert property (p_immediate) else $error("up key not applied at once");

  property p_faultClear;
    faultClear && !faultEvent |=> faultFlat == '0 && !clearArmed_q;
  endproperty
  a_faultClear: assert property (p_faultClear) else $error("fault records not cleared");

  property p_opPreset;
    wrOp && presetIn <= kcs_pkg::PRESET_MAX |=> opHours == 16'($past(presetIn) * 16'h000A);
  endproperty
  a_opPreset: assert property (p_opPreset) else $error("operation hours preset wrong");

  property p_initKeeps;
    wrInit && !faultEvent && !faultClear |=> $stable(faultFlat);
  endproperty
  a_initKeeps: assert property (p_initKeeps) else $error("initialise touched fault records");

  c_toggle: cover property (toggleOk ##1 local_q);
  c_remoteStop: cover property (!local_q && runCmd ##1 stopKill ##1 !runCmd);
  c_saved: cover property (freqSaveStrobe);
  c_clear: cover property (faultClear);

endmodule : kcs_ctrl

`default_nettype wire

// >>> logic/kcs_hour_counter.sv
// Saturating hour counter with a synchronous preset load.
// Assumes tick is a one-cycle pulse once per hour.
`timescale 1ns/1ps
`default_nettype none

module kcs_hour_counter (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Control
  input wire logic tick,
  input wire logic enable,
  input wire logic load,
  input wire logic [kcs_pkg::HOURS_W-1:0] loadValue,
  // Count
  output logic [kcs_pkg::HOURS_W-1:0] hours
);

  wire atMax = (hours == kcs_pkg::HOURS_MAX);

  // Load wins over a tick in the same cycle; no wrap at the top
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      hours <= '0;
    else if (load)
      hours <= loadValue;
    else if (tick && enable && !atMax)
      hours <= hours + 16'h0001;
  end

endmodule : kcs_hour_counter

`default_nettype wire

// >>> logic/kcs_pkg.sv
// Constants, field layouts and carrier types for the keypad command source controller.
// Assumes a single 100 MHz clock and an APB register port with 8-bit byte addresses.
`default_nettype none

package kcs_pkg;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned FREQ_SAVE_TIME_S = 5;
  localparam longint unsigned FREQ_SAVE_CYCLES = FREQ_SAVE_TIME_S * CLK_HZ;
  localparam longint unsigned HOUR_TIME_S = 3600;
  localparam longint unsigned HOUR_CYCLES = HOUR_TIME_S * CLK_HZ;

  // ***********************************************
  // Register offsets
  // ***********************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CAP = 8'h04;
  localparam logic [7:0] REG_OPTIME = 8'h08;
  localparam logic [7:0] REG_FANTIME = 8'h0C;
  localparam logic [7:0] REG_FAULTCLR = 8'h10;
  localparam logic [7:0] REG_FAULTREC = 8'h14;
  localparam logic [7:0] REG_INIT = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_FREQ = 8'h20;
  localparam logic [7:0] REG_SAVED = 8'h24;

  // ***********************************************
  // Field positions and reset values
  // ***********************************************
  localparam int CTRL_W = 10;
  localparam int CTRL_SW_EN = 0;
  localparam int CTRL_RUN_AFTER = 1;
  localparam int CTRL_STOP_OVR = 2;
  localparam int CTRL_ENTER_SEL = 3;
  localparam int CTRL_PWRUP_DIR = 4;
  localparam int CTRL_OPTIME_MODE = 5;
  localparam int CTRL_SRC1_LSB = 6;
  localparam int CTRL_SRC2_LSB = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h005;
  localparam int CLR_ARM_BIT = 0;
  localparam int INIT_BIT = 0;
  localparam logic [1:0] SRC_KEYPAD = 2'h0;

  localparam int CAP_W = 6;
  localparam logic [CAP_W-1:0] CAP_200V_MAX = 6'h0E;
  localparam logic [CAP_W-1:0] CAP_400V_MIN = 6'h20;
  localparam logic [CAP_W-1:0] CAP_400V_MAX = 6'h2E;

  localparam int HOURS_W = 16;
  localparam logic [HOURS_W-1:0] HOURS_PER_UNIT = 16'h000A;
  localparam logic [HOURS_W-1:0] PRESET_MAX = 16'h0258;
  localparam logic [HOURS_W-1:0] HOURS_MAX = 16'hFFFF;

  localparam int FREQ_W = 16;
  localparam logic [FREQ_W-1:0] FREQ_MAX = 16'hFFFF;
  localparam logic [FREQ_W-1:0] FREQ_STEP = 16'h0001;

  localparam int FAULT_DEPTH = 4;
  localparam int FAULT_W = 8;

  // ***********************************************
  // Carriers
  // ***********************************************
  typedef struct packed {
    logic localRemote;
    logic stop;
    logic run;
    logic up;
    logic down;
    logic enter;
  } kcs_keys_t;

  typedef struct packed {
    logic [1:0] runSourceSelectSecondary;
    logic [1:0] runSourceSelectPrimary;
    logic operationTimeMode;
    logic powerupDirectionSelect;
    logic enterRequiredSelect;
    logic stopKeyOverride;
    logic runAfterSwitchSelect;
    logic sourceSwitchEnable;
  } kcs_cfg_t;

endpackage : kcs_pkg

`default_nettype wire

// >>> logic/kcs_tick_div.sv
// Divides the system clock into a one-cycle enable pulse every DIV cycles.
// Assumes DIV is at least one.
`timescale 1ns/1ps
`default_nettype none

module kcs_tick_div #(
  parameter logic [39:0] DIV = 40'h00_0000_0001
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Pulse out
  output logic tick
);

  logic [39:0] cnt_q;
  wire atEnd = (cnt_q == (DIV - 40'h00_0000_0001));

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt_q <= atEnd ? '0 : cnt_q + 40'h00_0000_0001;
      tick <= atEnd;
    end
  end

endmodule : kcs_tick_div

`default_nettype wire
